// ### verilog/vanc_params.svh
`ifndef VANC_PARAMS_SVH
`define VANC_PARAMS_SVH

// ---------------------------------------------------------------
// Word widths and counts
// ---------------------------------------------------------------
`define VANC_W          16
`define VANC_LAG_W      8
`define VANC_ACF_N      9
`define VANC_RC_N       4
`define VANC_LAG_N      4

// ---------------------------------------------------------------
// Pseudo-float constants, exponent and mantissa
// ---------------------------------------------------------------
`define VANC_E_PTH      16'h0012
`define VANC_M_PTH      16'h668a
`define VANC_E_MARGIN   16'h001b
`define VANC_M_MARGIN   16'h6acf
`define VANC_E_PLEV     16'h0014
`define VANC_M_PLEV     16'h445c
`define VANC_E_THVAD0   16'h0015
`define VANC_M_THVAD0   16'h5573
`define VANC_MAN_MIN    16'h4000

// ---------------------------------------------------------------
// Tone and periodicity constants, fractions in Q15
// ---------------------------------------------------------------
`define VANC_FREQTH     32'h00000c74
`define VANC_PREDTH     16'h05b9
`define VANC_ONE_Q15    32'h00008000
`define VANC_LTHRESH    8'h02
`define VANC_NTHRESH    4'h7
`define VANC_LAG0_INIT  8'h15

`endif

// ### verilog/vanc_pkg.sv
`default_nettype none
`include "vanc_params.svh"

package vanc_pkg;

  // Sequencer phases of the frame.
  typedef enum logic [1:0] {
    VANC_IDLE   = 2'b00,
    VANC_DECIDE = 2'b01,
    VANC_PERIOD = 2'b10
  } vanc_state_e;

  typedef logic [`VANC_W-1:0] vanc_word_t;

  // Complete state of the numeric core.
  typedef struct packed {
    vanc_state_e                               st;
    logic [`VANC_ACF_N-1:0]                    acf_mask;
    logic [`VANC_RC_N-1:0]                     rc_mask;
    logic [2:0]                                lag_cnt;
    logic [`VANC_RC_N-1:0][`VANC_W-1:0]        rc;
    logic [`VANC_LAG_N:0][`VANC_LAG_W-1:0]     lags;
    vanc_word_t                                en_exp;
    vanc_word_t                                en_man;
    vanc_word_t                                th_exp;
    vanc_word_t                                th_man;
    logic [2:0]                                old_cnt;
    logic [2:0]                                vold_cnt;
    logic                                      ptch;
    logic                                      tone;
    logic                                      vad;
    logic                                      dec_done;
    logic                                      per_done;
    logic                                      bsy;
  } vanc_state_s;

endpackage : vanc_pkg

`default_nettype wire

// ### verilog/vanc_pfcmp.sv
`timescale 1ns/1ps
`default_nettype none

// Pseudo-float magnitude compare: a_lt_b when value a is below value b.
module vanc_pfcmp (
  input  wire logic [15:0] a_exp,
  input  wire logic [15:0] a_man,
  input  wire logic [15:0] b_exp,
  input  wire logic [15:0] b_man,
  output logic             a_lt_b
);

  // Exponent decides first, mantissa only breaks a tie.
  always_comb begin
    if (a_exp != b_exp) begin
      a_lt_b = ($signed(a_exp) < $signed(b_exp));
    end else begin
      a_lt_b = (a_man < b_man);
    end
  end

endmodule : vanc_pfcmp

`default_nettype wire

// ### verilog/vanc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "vanc_params.svh"

// Functional notes
// - Reset loads every detector state variable with its starting value before any frame.
// - The decision starts only once autocorrelation words 0..8 and reflection words 1..4 are in.
// - The decision reads neither the periodic flag nor the current lags.
// - The periodicity update runs from the four subframe lags after the frame is encoded.
// - Filtered energy, threshold and input energy are each a 16-bit exponent plus mantissa.
// - A pseudo-float is 2^exp times mantissa/32768 with a mantissa of at least 16384.
// - Pseudo-float magnitudes are compared on their exponents first.
// - All pseudo-float and tone arithmetic uses only 16-bit or 32-bit integer operations.
// - Energy floor 18/26250, margin 27/27343 and lower limit 20/17500 are held as pairs.
// - The pole test builds second-order coefficients from the first two reflections, a0 one.
// - The real part is minus half of a1 and the imaginary term is (4*a2 - a1^2)/4.
// - A negative imaginary term means real poles, so the frame is not a tone.
// - A negative real part means a pole above 2000 Hz, so the error test follows directly.
// - With both terms positive, im/a1^2 below 0.0973/4 means not a tone, else the error test.
// - The frame is a tone when the normalized prediction error is below 0.0447.
module vanc_core
  import vanc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 acf_wr,
  input  wire logic [3:0]           acf_idx,
  input  wire logic [15:0]          acf_exp,
  input  wire logic [15:0]          acf_man,
  input  wire logic                 rc_wr,
  input  wire logic [1:0]           rc_idx,
  input  wire logic [15:0]          rc_data,
  input  wire logic [15:0]          pvad_exp,
  input  wire logic [15:0]          pvad_man,
  input  wire logic                 lag_wr,
  input  wire logic [7:0]           lag_data,
  input  wire logic                 frame_encoded,
  output logic                      vad_flag,
  output logic                      tone_flag,
  output logic                      periodic_flag,
  output logic                      decision_done,
  output logic                      period_done,
  output logic                      busy
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  vanc_state_s s_r;
  vanc_state_s s_nxt;

  logic        en_below_pth;
  logic        pvad_below_th;

  // ---------------------------------------------------------------
  // Pseudo-float comparators
  // ---------------------------------------------------------------
  // Input energy against the energy floor constant.
  vanc_pfcmp u_cmp_floor (
    .a_exp  (s_r.en_exp),
    .a_man  (s_r.en_man),
    .b_exp  (`VANC_E_PTH),
    .b_man  (`VANC_M_PTH),
    .a_lt_b (en_below_pth)
  );

  // Threshold against filtered energy: pvad above thvad when th < pvad.
  vanc_pfcmp u_cmp_vad (
    .a_exp  (s_r.th_exp),
    .a_man  (s_r.th_man),
    .b_exp  (pvad_exp),
    .b_man  (pvad_man),
    .a_lt_b (pvad_below_th)
  );

  // ---------------------------------------------------------------
  // Pole test
  // ---------------------------------------------------------------
  logic signed [31:0] rc1;
  logic signed [31:0] rc2;
  logic signed [31:0] a1;
  logic signed [31:0] a1sq;
  logic signed [31:0] im;
  logic signed [31:0] lowf_lim;
  logic               re_neg;
  logic               pole_ok;

  // Second-order step-up with a0 fixed at one, all in Q15 on 32 bits.
  always_comb begin
    rc1      = 32'($signed(s_r.rc[0]));
    rc2      = 32'($signed(s_r.rc[1]));
    a1       = rc1 + ((rc1 * rc2) >>> 15);
    if (a1 > 32'sh00007fff) begin
      a1 = 32'sh00007fff;
    end else if (a1 < -32'sh00008000) begin
      a1 = -32'sh00008000;
    end
    a1sq     = a1 * a1;
    im       = (rc2 <<< 15) - (a1sq >>> 2);
    re_neg   = (a1 > 32'sh0);  // Minus half of a1 is negative.
    lowf_lim = (((a1sq >>> 15) * $signed(`VANC_FREQTH)) >>> 2);
    if (im < 32'sh0) begin
      pole_ok = 1'b0;
    end else if (re_neg) begin
      pole_ok = 1'b1;
    end else begin
      pole_ok = !(im < lowf_lim);
    end
  end

  // ---------------------------------------------------------------
  // Normalized prediction error, product of (1 - rc^2)
  // ---------------------------------------------------------------
  logic [31:0] perr;
  logic [31:0] sq;
  always_comb begin
    perr = `VANC_ONE_Q15;
    sq   = 32'h0;
    for (int k = 0; k < `VANC_RC_N; k++) begin
      sq   = 32'(($signed(s_r.rc[k]) * $signed(s_r.rc[k])) >>> 15);
      perr = ((perr * (`VANC_ONE_Q15 - sq)) >> 15);
    end
  end

  // ---------------------------------------------------------------
  // Periodicity: one hit per lag pair
  // ---------------------------------------------------------------
  logic [`VANC_LAG_N-1:0] lag_hit;
  genvar gj;
  generate
    for (gj = 1; gj <= `VANC_LAG_N; gj++) begin : g_lag
      logic [7:0] big;
      logic [7:0] sml;
      logic [7:0] rem;
      logic [7:0] mn;
      always_comb begin
        big = (s_r.lags[gj] > s_r.lags[gj-1]) ? s_r.lags[gj] : s_r.lags[gj-1];
        sml = (s_r.lags[gj] > s_r.lags[gj-1]) ? s_r.lags[gj-1] : s_r.lags[gj];
        rem = big;
        mn  = 8'h0;
        for (int i = 1; i <= 3; i++) begin
          mn = (s_r.lags[i] < s_r.lags[i-1]) ? s_r.lags[i] : s_r.lags[i-1];
          if (rem >= mn) begin
            rem = rem - mn;
          end
        end
        mn = sml - rem;
        lag_hit[gj-1] = (((rem < mn) ? rem : mn) < `VANC_LTHRESH);
      end
    end
  endgenerate

  logic [2:0] lag_sum;
  always_comb begin
    lag_sum = 3'h0;
    for (int k = 0; k < `VANC_LAG_N; k++) begin
      lag_sum = lag_sum + 3'(lag_hit[k]);
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.dec_done = 1'b0;
    s_nxt.per_done = 1'b0;
    case (s_r.st)
      VANC_IDLE: begin
        // Collect frame inputs; energy word 0 carries the pseudo-float pair.
        if (acf_wr && (acf_idx < 4'(`VANC_ACF_N))) begin
          s_nxt.acf_mask[acf_idx] = 1'b1;
          if (acf_idx == 4'h0) begin
            s_nxt.en_exp = acf_exp;
            s_nxt.en_man = acf_man;
          end
        end
        if (rc_wr) begin
          s_nxt.rc_mask[rc_idx] = 1'b1;
          s_nxt.rc[rc_idx]      = rc_data;
        end
        if (lag_wr && (s_r.lag_cnt < 3'(`VANC_LAG_N))) begin
          s_nxt.lags[s_r.lag_cnt + 3'h1] = lag_data;
          s_nxt.lag_cnt                  = s_r.lag_cnt + 3'h1;
        end
        if ((&s_r.acf_mask) && (&s_r.rc_mask)) begin
          s_nxt.st = VANC_DECIDE;
        end else if (frame_encoded && (s_r.lag_cnt == 3'(`VANC_LAG_N))) begin
          s_nxt.st = VANC_PERIOD;
        end
      end
      VANC_DECIDE: begin
        // Decision does not read the periodic flag; ptch is left alone here.
        s_nxt.vad      = pvad_below_th;
        s_nxt.tone     = pole_ok && (perr < 32'(`VANC_PREDTH));
        if (en_below_pth) begin
          s_nxt.th_exp = `VANC_E_PLEV;
          s_nxt.th_man = `VANC_M_PLEV;
        end
        s_nxt.acf_mask = '0;
        s_nxt.rc_mask  = '0;
        s_nxt.dec_done = 1'b1;
        s_nxt.st       = VANC_IDLE;
      end
      VANC_PERIOD: begin
        s_nxt.vold_cnt = s_r.old_cnt;
        s_nxt.old_cnt  = lag_sum;
        s_nxt.ptch     = ({1'b0, lag_sum} + {1'b0, s_r.old_cnt}) >= `VANC_NTHRESH;
        s_nxt.lags[0]  = s_r.lags[`VANC_LAG_N];
        s_nxt.lag_cnt  = 3'h0;
        s_nxt.per_done = 1'b1;
        s_nxt.st       = VANC_IDLE;
      end
      default: begin
        s_nxt.st = VANC_IDLE;
      end
    endcase
    // Busy is kept in a flip-flop so the output needs no decode.
    s_nxt.bsy = (s_nxt.st != VANC_IDLE);
  end

  // ---------------------------------------------------------------
  // State register with starting values
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r          <= '0;
      s_r.st       <= VANC_IDLE;
      s_r.lags[0]  <= `VANC_LAG0_INIT;
      s_r.th_exp   <= `VANC_E_THVAD0;
      s_r.th_man   <= `VANC_M_THVAD0;
      s_r.ptch     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign vad_flag      = s_r.vad;
  assign tone_flag     = s_r.tone;
  assign periodic_flag = s_r.ptch;
  assign decision_done = s_r.dec_done;
  assign period_done   = s_r.per_done;
  assign busy          = s_r.bsy;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_reset_start: assert property (@(posedge clk) $past(reset) && !reset |->
    s_r.ptch && s_r.th_exp == `VANC_E_THVAD0 && s_r.lags[0] == `VANC_LAG0_INIT)
    else $error("start values not loaded after reset");
  a_decide_gate: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE |-> (&s_r.acf_mask) && (&s_r.rc_mask))
    else $error("decision started with inputs missing");
  a_ptch_held: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE |=> $stable(s_r.ptch))
    else $error("periodic flag changed during decision");
  a_period_gate: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_PERIOD |-> s_r.lag_cnt == 3'h4 ##1 period_done)
    else $error("periodicity update without four lags");
  a_thvad_norm: assert property (@(posedge clk) disable iff (reset)
    s_r.th_man >= `VANC_MAN_MIN)
    else $error("threshold mantissa not normalized");
  a_cmp_exp: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE && $signed(pvad_exp) > $signed(s_r.th_exp) |=> vad_flag)
    else $error("larger exponent not detected");
  a_cmp_man: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE && pvad_exp == s_r.th_exp && pvad_man <= s_r.th_man
    |=> !vad_flag)
    else $error("mantissa tie-break wrong");
  a_real_pole: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE && im < 32'sh0 |=> !tone_flag ##1 !decision_done)
    else $error("real poles classified as tone");
  a_low_freq: assert property (@(posedge clk) disable iff (reset)
    s_r.st == VANC_DECIDE && !re_neg && im >= 32'sh0 && im < lowf_lim |=> !tone_flag)
    else $error("low pole frequency classified as tone");

endmodule : vanc_core

`default_nettype wire

// ### dv/vanc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Encoder model
// ---------------------------------------------------------------
// Hands the analysis results of one frame to the core, one strobe at a time.
module vanc_enc_model (
  input  wire logic        clk,
  input  wire logic        busy,
  output logic             acf_wr,
  output logic [3:0]       acf_idx,
  output logic [15:0]      acf_exp,
  output logic [15:0]      acf_man,
  output logic             rc_wr,
  output logic [1:0]       rc_idx,
  output logic [15:0]      rc_data,
  output logic [15:0]      pvad_exp,
  output logic [15:0]      pvad_man,
  output logic             lag_wr,
  output logic [7:0]       lag_data,
  output logic             frame_encoded
);
  // All strobes start low so nothing is written before reset ends.
  initial begin
    {acf_wr, rc_wr, lag_wr, frame_encoded} = 4'h0;
    {acf_idx, acf_exp, acf_man, rc_idx, rc_data} = 54'h0;
    {pvad_exp, pvad_man, lag_data} = 40'h0;
  end

  // Waits for a falling edge at which the core is not busy.
  task automatic free_wait();
    @(negedge clk);
    while (busy) @(negedge clk);
  endtask : free_wait

  // One autocorrelation word; the mantissa is scrambled once the strobe falls.
  task automatic put_acf(input logic [3:0] i, input logic [15:0] e, input logic [15:0] m);
    free_wait();
    acf_wr = 1'b1;
    acf_idx = i;
    acf_exp = e;
    acf_man = m;
    @(negedge clk);
    acf_wr = 1'b0;
    acf_man = ~m;
  endtask : put_acf

  // Reflection words first, then autocorrelation from index 9 down to last.
  task automatic send_frame(input logic [15:0] ee, em, pe, pm, r1, r2, r3, r4, fill,
                            input int last);
    logic [15:0] rs [4];
    rs = '{r1, r2, r3, r4};
    pvad_exp = pe;
    pvad_man = pm;
    for (int j = 0; j < 4; j++) begin
      free_wait();
      rc_wr = 1'b1;
      rc_idx = j[1:0];
      rc_data = rs[j];
      @(negedge clk);
      rc_wr = 1'b0;
      rc_data = ~rs[j];
    end
    for (int i = 9; i >= last; i--) begin
      put_acf(i[3:0], ee, (i == 0) ? em : fill ^ i[15:0]);
    end
  endtask : send_frame

  // Subframe lags, then the end-of-frame pulse when asked for.
  task automatic send_lags(input logic [7:0] v, input int n, input logic fe);
    for (int j = 0; j < n; j++) begin
      free_wait();
      lag_wr = 1'b1;
      lag_data = v;
      @(negedge clk);
      lag_wr = 1'b0;
      lag_data = ~v;
    end
    if (fe) begin
      free_wait();
      frame_encoded = 1'b1;
      @(negedge clk);
      frame_encoded = 1'b0;
    end
  endtask : send_lags
endmodule : vanc_enc_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vanc_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end

module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic acf_wr, rc_wr, lag_wr, frame_encoded, vad_flag, tone_flag, periodic_flag;
  logic decision_done, period_done, busy;
  logic [3:0] acf_idx;
  logic [1:0] rc_idx;
  logic [7:0] lag_data;
  logic [15:0] acf_exp, acf_man, rc_data, pvad_exp, pvad_man, re, rm;
  logic [16:0] lfsr_r = 17'h14d3d;
  logic [1:0] dq [$];
  logic pq [$];
  logic [1:0] got;
  int failures = 0;
  int samples_checked = 0;
  // Rows: energy exp/man, filtered energy exp/man, four reflections.
  localparam logic [15:0] TBL [8][8] = '{
    '{16'h0014, 16'h4000, 16'h0015, 16'h5573, 16'hc000, 16'h7eb8, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0015, 16'h5574, 16'h4000, 16'h7eb8, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0014, 16'h7fff, 16'h4000, 16'h8148, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0016, 16'h4000, 16'h4000, 16'h4000, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0015, 16'h5573, 16'ha28f, 16'h199a, 16'h7eb8, 16'h0000},
    '{16'h0012, 16'h6689, 16'h0016, 16'h4000, 16'h4000, 16'h4000, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0014, 16'h445d, 16'h4000, 16'h4000, 16'h0000, 16'h0000},
    '{16'h0014, 16'h4000, 16'h0014, 16'h445c, 16'h4000, 16'h4000, 16'h0000, 16'h0000}};
  // Expected {activity, tone} per row.
  localparam logic [1:0] EXV [8] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0};

  always #20 clk = ~clk;

  vanc_enc_model enc (.clk(clk), .busy(busy), .acf_wr(acf_wr), .acf_idx(acf_idx),
    .acf_exp(acf_exp), .acf_man(acf_man), .rc_wr(rc_wr), .rc_idx(rc_idx), .rc_data(rc_data),
    .pvad_exp(pvad_exp), .pvad_man(pvad_man), .lag_wr(lag_wr), .lag_data(lag_data),
    .frame_encoded(frame_encoded));

  vanc_core dut (.clk(clk), .reset(reset), .acf_wr(acf_wr), .acf_idx(acf_idx),
    .acf_exp(acf_exp), .acf_man(acf_man), .rc_wr(rc_wr), .rc_idx(rc_idx), .rc_data(rc_data),
    .pvad_exp(pvad_exp), .pvad_man(pvad_man), .lag_wr(lag_wr), .lag_data(lag_data),
    .frame_encoded(frame_encoded), .vad_flag(vad_flag), .tone_flag(tone_flag),
    .periodic_flag(periodic_flag), .decision_done(decision_done),
    .period_done(period_done), .busy(busy));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr_next

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Waits for every noted result, then idles so a stray pulse is seen.
  task automatic drain();
    int n;
    n = 0;
    while ((dq.size() + pq.size() != 0) && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("BAD completion expected pulse seen none");
    end
    repeat (4) @(negedge clk);
  endtask : drain

  // Holds reset for five cycles and checks the starting state.
  task automatic reset_dut();
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    `CHK("start flags", 5'b00100, {vad_flag, tone_flag, periodic_flag, decision_done, busy})
  endtask : reset_dut

  task automatic frame(input int k, input logic [1:0] ex);
    dq.push_back(ex);
    enc.send_frame(TBL[k][0], TBL[k][1], TBL[k][2], TBL[k][3], TBL[k][4], TBL[k][5],
                   TBL[k][6], TBL[k][7], lfsr_r[15:0], 0);
    drain();
  endtask : frame

  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  // Each completion pulse takes the oldest noted result off its queue.
  always @(negedge clk) begin
    if (decision_done) begin
      got = (dq.size() != 0) ? dq.pop_front() : 2'bxx;
      `CHK("vad_flag", got[1], vad_flag)
      `CHK("tone_flag", got[0], tone_flag)
    end
    if (period_done) begin
      got[0] = (pq.size() != 0) ? pq.pop_front() : 1'bx;
      `CHK("periodic_flag", got[0], periodic_flag)
    end
  end

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    reset_dut();
    for (int f = 0; f < 6; f++) begin
      lfsr_r = lfsr_next(lfsr_r);
      re = 16'h0012 + {13'h0, lfsr_r[2:0]};
      rm = {2'b01, lfsr_r[16:3]};
      dq.push_back({(re > `VANC_E_THVAD0) || (re == `VANC_E_THVAD0 && rm > `VANC_M_THVAD0),
                    1'b0});
      enc.send_frame(16'h0014, 16'h4000, re, rm, 16'h4000, 16'h4000, 16'h0000, 16'h0000,
                     lfsr_r[15:0], 0);
      drain();
    end
    for (int k = 0; k < 8; k++) begin
      frame(k, EXV[k]);
    end
    enc.send_frame(16'h0014, 16'h4000, 16'h0016, 16'h4000, 16'h4000, 16'h4000, 16'h0000,
                   16'h0000, lfsr_r[15:0], 1);
    repeat (6) @(negedge clk);
    dq.push_back(2'h2);
    enc.put_acf(4'h0, 16'h0014, 16'h4000);
    drain();
    enc.send_lags(8'h15, 3, 1'b1);
    drain();
    pq.push_back(1'b0);
    enc.send_lags(8'h15, 1, 1'b1);
    drain();
    reset_dut();
    frame(6, 2'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
